// *** common/lfpc_regs.svh ***
// Purpose: Offsets, field positions and reset values of the page-one receiver control bank.
// Assumes: Byte-wide registers on a plain address/strobe port.
// Notes:   Definitions only.
`ifndef LFPC_REGS_SVH
`define LFPC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LFPC_OFS_AMP_DEQ    8'h23
`define LFPC_OFS_SLICER     8'h24
`define LFPC_OFS_CARVAL     8'h25
`define LFPC_OFS_PAGE       8'h20

// ****************************************
// Reset values
// ****************************************
`define LFPC_RST_AMP_DEQ    8'hC8
`define LFPC_RST_SLICER     8'hC0
`define LFPC_RST_CARVAL     8'h00
`define LFPC_CARVAL_MASK    8'h0F
`define LFPC_AZ_RECOMMENDED 3'h6

// ****************************************
// Field positions
// ****************************************
`define LFPC_GAIN_MSB       7
`define LFPC_GAIN_LSB       6
`define LFPC_FIN_MSB        5
`define LFPC_FIN_LSB        4
`define LFPC_DATA_AUTOZERO_ENABLE_BIT       3
`define LFPC_DEQR_MSB       2
`define LFPC_DEQR_LSB       1
`define LFPC_DAMPING_SYSTEM_ENABLE_BIT      0
`define LFPC_HYST_MSB       7
`define LFPC_HYST_LSB       6
`define LFPC_BIPH_BIT       5
`define LFPC_OFFS_BIT       4
`define LFPC_POL_BIT        3
`define LFPC_AZC_MSB        2
`define LFPC_AZC_LSB        0
`define LFPC_CC_MSB         3
`define LFPC_CC_LSB         0

`endif

// *** common/lfpc_pkg.sv ***
// Purpose: Types shared by the page-one receiver control bank.
// Assumes: Nothing beyond the register header.
// Notes:   Types only; constants live in lfpc_regs.svh.
package lfpc_pkg;
  // Validation tracker states, one-hot
  typedef enum logic [2:0] {
    LFPC_IDLE  = 3'b001,
    LFPC_COUNT = 3'b010,
    LFPC_FOUND = 3'b100
  } lfpc_val_state_t;
endpackage

// *** core/lfpc_ctrl.sv ***
// Purpose: Page-one control registers, carrier validation counter and auto-zero edge trigger.
// Assumes: Single clock mclk_i; inputs synchronous; software sets the page bit itself.
// Notes:   Analog fields leave as plain register outputs for the analog front end.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "lfpc_regs.svh"

module lfpc_ctrl (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Page select from the receiver's page-zero bank
  input  wire logic       lf_page_select_i,
  // Receiver status
  input  wire logic       sample_done_i,
  input  wire logic       carrier_seen_i,
  input  wire logic       data_mode_i,
  input  wire logic       carrier_mode_i,
  input  wire logic       toggle_mode_i,
  input  wire logic       data_edge_i,
  input  wire logic       midbit_rising_i,
  input  wire logic       carrier_flag_clr_i,
  // Outputs to the analog chain and decoder
  output logic      [1:0] third_amp_gain_o,
  output logic      [1:0] log_amplifier_final_stage_o,
  output logic            data_autozero_enable_o,
  output logic      [1:0] deq_resistor_select_o,
  output logic            damping_system_enable_o,
  output logic      [1:0] slicer_threshold_window_o,
  output logic            avg_filter_biphase_on_o,
  output logic            avg_filter_offset_sel_o,
  output logic            manchester_edge_polarity_o,
  output logic            decoded_bit_o,
  output logic            decoded_bit_valid_o,
  output logic            carrier_detect_flag_o,
  output logic            chain_startup_o,
  output logic            auto_zero_req_o
);

  // ****************************************
  // Register decode
  // ****************************************
  logic [7:0] amp_deq;
  logic [7:0] slicer;
  logic [3:0] carval;

  // Page gate shields these offsets from the page-zero registers
  wire sel_amp  = lf_page_select_i && (addr_i == `LFPC_OFS_AMP_DEQ);
  wire sel_sli  = lf_page_select_i && (addr_i == `LFPC_OFS_SLICER);
  wire sel_cv   = lf_page_select_i && (addr_i == `LFPC_OFS_CARVAL);
  wire [7:0] rd_mux = sel_amp ? amp_deq :
                      sel_sli ? slicer :
                      sel_cv  ? {4'h0, carval} : 8'h00;

  // Register writes; reserved bits of the validation register are dropped
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amp_deq <= `LFPC_RST_AMP_DEQ;
      slicer  <= `LFPC_RST_SLICER;
      carval  <= 4'h0;
    end else if (wr_i) begin
      if (sel_amp) amp_deq <= wdata_i;
      if (sel_sli) slicer <= wdata_i;
      if (sel_cv) carval <= wdata_i[`LFPC_CC_MSB:`LFPC_CC_LSB];
    end
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_o <= 8'h00;
    else rdata_o <= rd_i ? rd_mux : 8'h00;
  end

  // ****************************************
  // Field outputs
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      third_amp_gain_o           <= 2'h3;
      log_amplifier_final_stage_o       <= 2'h0;
      data_autozero_enable_o     <= 1'b1;
      deq_resistor_select_o      <= 2'h0;
      damping_system_enable_o    <= 1'b0;
      slicer_threshold_window_o  <= 2'h3;
      avg_filter_biphase_on_o    <= 1'b0;
      avg_filter_offset_sel_o    <= 1'b0;
      manchester_edge_polarity_o <= 1'b0;
    end else begin
      third_amp_gain_o           <= amp_deq[`LFPC_GAIN_MSB:`LFPC_GAIN_LSB];
      log_amplifier_final_stage_o       <= amp_deq[`LFPC_FIN_MSB:`LFPC_FIN_LSB];
      data_autozero_enable_o     <= amp_deq[`LFPC_DATA_AUTOZERO_ENABLE_BIT];
      deq_resistor_select_o      <= amp_deq[`LFPC_DEQR_MSB:`LFPC_DEQR_LSB];
      damping_system_enable_o    <= amp_deq[`LFPC_DAMPING_SYSTEM_ENABLE_BIT];
      slicer_threshold_window_o  <= slicer[`LFPC_HYST_MSB:`LFPC_HYST_LSB];
      avg_filter_biphase_on_o    <= slicer[`LFPC_BIPH_BIT];
      avg_filter_offset_sel_o    <= slicer[`LFPC_OFFS_BIT];
      manchester_edge_polarity_o <= slicer[`LFPC_POL_BIT];
    end
  end

  // ****************************************
  // Manchester bit decode
  // ****************************************
  // Carrier-only frames carry no bits, so polarity is not applied there
  wire pol_eff  = carrier_mode_i ? 1'b0 : slicer[`LFPC_POL_BIT];
  wire next_bit = midbit_rising_i ^ pol_eff;
  wire bit_stb  = data_edge_i && data_mode_i && !carrier_mode_i;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      decoded_bit_o       <= 1'b0;
      decoded_bit_valid_o <= 1'b0;
    end else begin
      decoded_bit_o       <= bit_stb ? next_bit : decoded_bit_o;
      decoded_bit_valid_o <= bit_stb;
    end
  end

  // ****************************************
  // Auto-zero edge trigger
  // ****************************************
  // Counts data edges since the last request; saturates to avoid wrap
  logic [2:0] az_edges;
  wire [2:0] az_target = slicer[`LFPC_AZC_MSB:`LFPC_AZC_LSB];
  wire az_fire = data_mode_i && amp_deq[`LFPC_DATA_AUTOZERO_ENABLE_BIT] && data_edge_i
                 && (az_edges >= az_target);
  wire [2:0] next_az_edges = !data_mode_i ? 3'h0 :
                             az_fire ? 3'h0 :
                             (data_edge_i && az_edges != 3'h7) ? 3'(az_edges + 3'h1) : az_edges;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      az_edges        <= 3'h0;
      auto_zero_req_o <= 1'b0;
    end else begin
      az_edges        <= next_az_edges;
      auto_zero_req_o <= az_fire;
    end
  end

  // ****************************************
  // Consecutive carrier validation
  // ****************************************
  lfpc_pkg::lfpc_val_state_t state;
  lfpc_pkg::lfpc_val_state_t next_state;
  logic [4:0] cc_cnt;
  logic       started;

  wire cnt_hold = data_mode_i || toggle_mode_i;
  wire hit      = sample_done_i && carrier_seen_i && !cnt_hold;
  wire miss     = sample_done_i && !carrier_seen_i;
  wire [4:0] cnt_inc = 5'(cc_cnt + 5'h01);
  wire reach    = hit && (cnt_inc == 5'({1'b0, carval} + 5'h01));
  wire [4:0] next_cc = (cnt_hold || miss || reach) ? 5'h00 :
                       hit ? cnt_inc : cc_cnt;

  always_comb begin
    next_state = state;
    unique case (state)
      lfpc_pkg::LFPC_IDLE:  if (hit) next_state = reach ? lfpc_pkg::LFPC_FOUND : lfpc_pkg::LFPC_COUNT;
      lfpc_pkg::LFPC_COUNT: if (cnt_hold || miss) next_state = lfpc_pkg::LFPC_IDLE;
                            else if (reach) next_state = lfpc_pkg::LFPC_FOUND;
      lfpc_pkg::LFPC_FOUND: next_state = lfpc_pkg::LFPC_IDLE;
      default:              next_state = lfpc_pkg::LFPC_IDLE;
    endcase
  end

  // Flag: set wins over a clear arriving in the same cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state                 <= lfpc_pkg::LFPC_IDLE;
      cc_cnt                <= 5'h00;
      carrier_detect_flag_o <= 1'b0;
      started               <= 1'b0;
      chain_startup_o       <= 1'b0;
    end else begin
      state                 <= next_state;
      cc_cnt                <= next_cc;
      carrier_detect_flag_o <= reach | (carrier_detect_flag_o & ~carrier_flag_clr_i);
      started               <= started | reach;
      chain_startup_o       <= reach & ~started;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  page_gate_a: assert property ((wr_i && !lf_page_select_i) |=> $stable(amp_deq) && $stable(slicer))
    else $error("Write landed while page bit clear");
  rd_reserved_a: assert property ((rd_i && sel_cv) |=> rdata_o[7:4] == 4'h0)
    else $error("Reserved bits read nonzero");
  gain_out_a: assert property (##1 1'b1 |-> third_amp_gain_o == $past(amp_deq[7:6]))
    else $error("Gain output mismatch");
  flag_set_a: assert property (reach |=> carrier_detect_flag_o)
    else $error("Flag missed at threshold");
  miss_clr_a: assert property (miss |=> cc_cnt == 5'h00)
    else $error("Count not cleared by miss");
  hold_cnt_a: assert property (cnt_hold |=> cc_cnt == 5'h00 && !chain_startup_o ##0 1'b1)
    else $error("Count moved in data or toggle mode");
  startup_once_a: assert property (chain_startup_o |=> !chain_startup_o [*2])
    else $error("Startup pulse repeated");
  pol_carrier_a: assert property ((carrier_mode_i) |-> !bit_stb)
    else $error("Bit decoded in carrier mode");
  az_fire_a: assert property (az_fire |=> auto_zero_req_o && az_edges == 3'h0)
    else $error("Auto-zero request missing");
  az_gate_a: assert property (!amp_deq[3] |=> !auto_zero_req_o)
    else $error("Auto-zero while disabled");

  // ****************************************
  // Register port checks
  // ****************************************

  // Idle bus must read back zero, not stale data
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("Read data not zero without strobe");

  // Page-zero reads must not see this bank
  rd_nopage_a: assert property ((rd_i && !lf_page_select_i) |=> rdata_o == 8'h00)
    else $error("Read answered while page bit clear");

  // Read returns the register as it stood at the strobe
  rd_amp_a: assert property ((rd_i && sel_amp) |=> rdata_o == $past(amp_deq))
    else $error("Read data differs from register");

  // Only the low nibble of the validation register is kept
  cv_write_a: assert property ((wr_i && sel_cv) |=> carval == $past(wdata_i[3:0]))
    else $error("Validation field write lost");

  // ****************************************
  // Field output checks
  // ****************************************

  // Outputs trail their register by one flop stage
  final_out_a: assert property (##1 1'b1 |-> log_amplifier_final_stage_o == $past(amp_deq[5:4]))
    else $error("Final stage output mismatch");

  // Auto-zero permit follows bit 3
  data_autozero_enable_out_a: assert property (##1 1'b1 |-> data_autozero_enable_o == $past(amp_deq[3]))
    else $error("Auto-zero enable output mismatch");

  // Resistor choice follows bits 2:1
  deqr_out_a: assert property (##1 1'b1 |-> deq_resistor_select_o == $past(amp_deq[2:1]))
    else $error("Resistor select output mismatch");

  // Damping enable follows bit 0
  damping_system_enable_out_a: assert property (##1 1'b1 |-> damping_system_enable_o == $past(amp_deq[0]))
    else $error("Damping enable output mismatch");

  // Hysteresis code follows bits 7:6
  hyst_out_a: assert property (##1 1'b1 |-> slicer_threshold_window_o == $past(slicer[7:6]))
    else $error("Hysteresis output mismatch");

  // Filter mode pair follows bits 5:4
  filter_out_a: assert property (##1 1'b1 |->
                                 {avg_filter_biphase_on_o, avg_filter_offset_sel_o} == $past(slicer[5:4]))
    else $error("Filter mode output mismatch");

  // Polarity output follows bit 3
  pol_out_a: assert property (##1 1'b1 |-> manchester_edge_polarity_o == $past(slicer[3]))
    else $error("Polarity output mismatch");

  // ****************************************
  // Decode and auto-zero checks
  // ****************************************

  // Polarity one swaps the meaning of a rising edge
  bit_map_a: assert property (bit_stb |=> decoded_bit_o == ($past(midbit_rising_i) ^ $past(slicer[3])))
    else $error("Decoded bit has wrong polarity");

  // Every decoded edge is announced for one cycle
  bit_valid_a: assert property (bit_stb |=> decoded_bit_valid_o)
    else $error("Decoded bit not flagged valid");

  // Carrier-only frames never produce a bit
  carrier_nobit_a: assert property (carrier_mode_i |=> !decoded_bit_valid_o)
    else $error("Bit flagged valid in carrier mode");

  // Outside data frames the edge count restarts
  az_quiet_a: assert property (!data_mode_i |=> az_edges == 3'h0 && !auto_zero_req_o)
    else $error("Auto-zero activity outside data mode");

  // Each counted edge advances the spacing count by one
  az_count_a: assert property ((data_edge_i && data_mode_i && !az_fire && az_edges != 3'h7)
                               |=> az_edges == 3'($past(az_edges) + 3'h1))
    else $error("Edge count did not advance");

  // ****************************************
  // Validation counter checks
  // ****************************************

  // Flag is sticky until software clears it
  flag_hold_a: assert property ((carrier_detect_flag_o && !carrier_flag_clr_i) |=> carrier_detect_flag_o)
    else $error("Flag dropped without clear");

  // A clear with no new validation drops the flag
  flag_clr_a: assert property ((carrier_flag_clr_i && !reach) |=> !carrier_detect_flag_o)
    else $error("Flag survived clear");

  // A validation in the clear cycle must not be lost
  set_wins_a: assert property ((reach && carrier_flag_clr_i) |=> carrier_detect_flag_o)
    else $error("Clear beat a new validation");

  // A hit short of the target adds exactly one
  hit_count_a: assert property ((hit && !reach) |=> cc_cnt == $past(cnt_inc))
    else $error("Hit did not advance count");

  // Startup pulse only ever comes with the flag
  startup_flag_a: assert property (chain_startup_o |-> carrier_detect_flag_o)
    else $error("Startup without flag");

  // After the first validation no further startup
  startup_after_a: assert property (started |=> !chain_startup_o)
    else $error("Startup after first validation");

  // Toggle mode stops carrier hit counting
  toggle_nohit_a: assert property (toggle_mode_i |-> !hit)
    else $error("Hit counted in toggle mode");

  // Found state always shows the flag
  found_flag_a: assert property (state == lfpc_pkg::LFPC_FOUND |-> carrier_detect_flag_o)
    else $error("Found state without flag");

  flag_cov_c: cover property (hit ##[1:40] reach);
  az_cov_c:   cover property (auto_zero_req_o);
  miss_cov_c: cover property (hit ##[1:20] miss);
  rd_cov_c:   cover property (wr_i && sel_amp ##1 rd_i && sel_amp);
  boot_cov_c: cover property (chain_startup_o);

endmodule

// *** verif/lfpc_ctrl_bench.sv ***
// Purpose: Self-checking bench for the page-one receiver control bank.
// Assumes: Inputs change by non-blocking assignment just after a rising edge.
// Notes:   One-cycle pulses are counted at every edge so none is missed.
`timescale 1ns/100ps
`include "lfpc_regs.svh"

module lfpc_ctrl_bench;
  logic       mclk, resetn, wr, rd, page, smp, seen, dmode, cmode, tmode, dedge, rising, fclr;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] gain, fin, deqr, hyst;
  logic       data_autozero_enable, damping_system_enable, biph, offs, pol, dbit, dval, flag, start, azreq;
  int         failures, checks, starts, azs;

  lfpc_ctrl u_lfpc_ctrl (.mclk_i(mclk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .lf_page_select_i(page), .sample_done_i(smp), .carrier_seen_i(seen),
    .data_mode_i(dmode), .carrier_mode_i(cmode), .toggle_mode_i(tmode), .data_edge_i(dedge),
    .midbit_rising_i(rising), .carrier_flag_clr_i(fclr), .third_amp_gain_o(gain),
    .log_amplifier_final_stage_o(fin), .data_autozero_enable_o(data_autozero_enable), .deq_resistor_select_o(deqr),
    .damping_system_enable_o(damping_system_enable), .slicer_threshold_window_o(hyst), .avg_filter_biphase_on_o(biph),
    .avg_filter_offset_sel_o(offs), .manchester_edge_polarity_o(pol), .decoded_bit_o(dbit),
    .decoded_bit_valid_o(dval), .carrier_detect_flag_o(flag), .chain_startup_o(start),
    .auto_zero_req_o(azreq));

  // Clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Pulse counters, sampled where the pulse stands
  always @(posedge mclk) begin
    if (start === 1'b1) starts++;
    if (azreq === 1'b1) azs++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Field outputs trail the write edge by one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    cyc(2);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask
  task automatic sample(input logic hit);
    @(posedge mclk);
    smp <= 1'b1; seen <= hit;
    @(posedge mclk);
    smp <= 1'b0;
    cyc(2);
  endtask
  task automatic edge_in(input logic r);
    @(posedge mclk);
    dedge <= 1'b1; rising <= r;
    @(posedge mclk);
    dedge <= 1'b0;
    #1;
  endtask
  task automatic flag_clr();
    @(posedge mclk);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    cyc(1);
  endtask
  task automatic set_modes(input logic d, input logic c, input logic t);
    @(posedge mclk);
    dmode <= d; cmode <= c; tmode <= t;
    cyc(2);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    chk("gain", {6'h0, gain}, 8'h03);
    chk("data_autozero_enable", {7'h0, data_autozero_enable}, 8'h01);
    chk("damping_system_enable", {7'h0, damping_system_enable}, 8'h00);
    chk("hyst", {6'h0, hyst}, 8'h03);
    chk("pol", {7'h0, pol}, 8'h00);
    rd_chk(`LFPC_OFS_AMP_DEQ, 8'hC8);
    rd_chk(`LFPC_OFS_SLICER, 8'hC0);
    rd_chk(`LFPC_OFS_CARVAL, 8'h00);
    $display("test reset done");
  endtask

  // Every code of the two-bit fields and damping, then refused accesses
  task automatic test_fields();
    for (int i = 0; i < 4; i++) begin
      wr_reg(`LFPC_OFS_AMP_DEQ, {i[1:0], i[1:0], 1'b1, i[1:0], i[0]});
      wr_reg(`LFPC_OFS_SLICER, {i[1:0], i[1:0], 4'h6});
      chk("gain", {6'h0, gain}, 8'(i));
      chk("final", {6'h0, fin}, 8'(i));
      chk("deqr", {6'h0, deqr}, 8'(i));
      chk("damping_system_enable", {7'h0, damping_system_enable}, {7'h0, i[0]});
      chk("hyst", {6'h0, hyst}, 8'(i));
      chk("filter", {6'h0, biph, offs}, 8'(i));
      rd_chk(`LFPC_OFS_SLICER, {i[1:0], i[1:0], 4'h6});
    end
    wr_reg(`LFPC_OFS_CARVAL, 8'hFF);
    rd_chk(`LFPC_OFS_CARVAL, 8'h0F);
    @(posedge mclk);
    page <= 1'b0;
    wr_reg(`LFPC_OFS_AMP_DEQ, 8'h00);
    rd_chk(`LFPC_OFS_AMP_DEQ, 8'h00);
    chk("gain", {6'h0, gain}, 8'h03);
    @(posedge mclk);
    page <= 1'b1;
    rd_chk(`LFPC_OFS_AMP_DEQ, 8'hFF);
    rd_chk(8'h26, 8'h00);
    $display("test fields done");
  endtask

  task automatic test_decode();
    set_modes(1'b1, 1'b0, 1'b0);
    wr_reg(`LFPC_OFS_SLICER, 8'hC0);
    edge_in(1'b1); chk("dbit", {7'h0, dbit}, 8'h01);
    chk("dval", {7'h0, dval}, 8'h01);
    edge_in(1'b0); chk("dbit", {7'h0, dbit}, 8'h00);
    wr_reg(`LFPC_OFS_SLICER, 8'hC8);
    chk("pol", {7'h0, pol}, 8'h01);
    edge_in(1'b1); chk("dbit", {7'h0, dbit}, 8'h00);
    set_modes(1'b1, 1'b1, 1'b0);
    edge_in(1'b1); chk("dbit", {7'h0, dbit}, 8'h00);
    chk("dval", {7'h0, dval}, 8'h00);
    $display("test decode done");
  endtask

  // Edge count two: the third edge fires
  task automatic test_autozero();
    set_modes(1'b0, 1'b0, 1'b0);
    wr_reg(`LFPC_OFS_SLICER, 8'hC2);
    wr_reg(`LFPC_OFS_AMP_DEQ, 8'hC8);
    set_modes(1'b1, 1'b0, 1'b0);
    azs = 0;
    repeat (2) edge_in(1'b1);
    cyc(2); chk("az", azs[7:0], 8'h00);
    edge_in(1'b0);
    cyc(2); chk("az", azs[7:0], 8'h01);
    repeat (3) edge_in(1'b1);
    cyc(2); chk("az", azs[7:0], 8'h02);
    wr_reg(`LFPC_OFS_AMP_DEQ, 8'hC0);
    repeat (4) edge_in(1'b1);
    cyc(2); chk("az", azs[7:0], 8'h02);
    set_modes(1'b0, 1'b0, 1'b0);
    $display("test autozero done");
  endtask

  // Field one: two consecutive hits raise the flag
  task automatic test_validate();
    wr_reg(`LFPC_OFS_CARVAL, 8'h01);
    sample(1'b1); chk("flag", {7'h0, flag}, 8'h00);
    sample(1'b0);
    sample(1'b1); chk("flag", {7'h0, flag}, 8'h00);
    sample(1'b1); chk("flag", {7'h0, flag}, 8'h01);
    chk("starts", starts[7:0], 8'h01);
    flag_clr(); chk("flag", {7'h0, flag}, 8'h00);
    repeat (2) sample(1'b1);
    chk("flag", {7'h0, flag}, 8'h01);
    chk("starts", starts[7:0], 8'h01);
    flag_clr();
    sample(1'b1);
    set_modes(1'b1, 1'b0, 1'b0);
    repeat (2) sample(1'b1);
    set_modes(1'b0, 1'b0, 1'b0);
    sample(1'b1); chk("flag", {7'h0, flag}, 8'h00);
    flag_clr();
    set_modes(1'b0, 1'b0, 1'b1);
    repeat (3) sample(1'b1);
    chk("flag", {7'h0, flag}, 8'h00);
    $display("test validate done");
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog bounds the whole run
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    test_done();
  end

  // Main sequence
  initial begin
    {resetn, wr, rd, smp, seen, dmode, cmode, tmode, dedge, rising, fclr} = '0;
    {addr, wdata} = '0;
    page = 1'b1;
    failures = 0; checks = 0; starts = 0; azs = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    cyc(1);
    test_reset();
    test_fields();
    test_decode();
    test_autozero();
    test_validate();
    test_done();
  end
endmodule
